// ==== logic/drive_ref_pkg.sv ====
// constants for the drive reference conditioning block
package drive_ref_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MIN_SPEED = 8'h00;
  localparam logic [7:0] OFS_INCH_REF = 8'h04;
  localparam logic [7:0] OFS_BASIC_SPEED = 8'h08;
  localparam logic [7:0] OFS_PRESET_BASE = 8'h0C; // presets 1..7 at 0x0C..0x24
  localparam logic [7:0] OFS_JOG_REF1 = 8'h28;
  localparam logic [7:0] OFS_JOG_REF2 = 8'h2C;
  localparam logic [7:0] OFS_TQ_SEL = 8'h30;
  localparam logic [7:0] OFS_TQ_MAX = 8'h34;
  localparam logic [7:0] OFS_TQ_MIN = 8'h38;
  localparam logic [7:0] OFS_TQ_FILT = 8'h3C;
  localparam logic [7:0] OFS_TQ_ZERO = 8'h40;
  localparam logic [7:0] OFS_TQ_HYST = 8'h44;
  localparam logic [7:0] OFS_WIN_NEG = 8'h48;
  localparam logic [7:0] OFS_WIN_POS = 8'h4C;
  localparam logic [7:0] OFS_WIN_NEG_OFF = 8'h50;
  localparam logic [7:0] OFS_WIN_POS_OFF = 8'h54;
  localparam logic [7:0] OFS_TQ_SLEW = 8'h58;
  localparam logic [7:0] OFS_TQ_STEP = 8'h5C;
  localparam logic [7:0] OFS_TQ_ADD = 8'h60;
  localparam logic [7:0] OFS_OL_FLOOR = 8'h64;
  localparam logic [7:0] OFS_CTRL = 8'h68;
  localparam logic [7:0] OFS_STATUS = 8'h6C;
  localparam logic [7:0] OFS_SPEED_OUT = 8'h70;
  localparam logic [7:0] OFS_TORQUE_OUT = 8'h74;
  // control register bits
  localparam int CTRL_WINDOW_EN_BIT = 0;
  localparam int CTRL_OPEN_LOOP_BIT = 1;
  // status register bits
  localparam int ST_SPEED_MODE_BIT = 0;
  localparam int ST_JOG_BIT = 1;
  localparam int ST_STOP_BIT = 2;
  localparam int ST_FB_JOG_BIT = 3;
  // reset values
  localparam logic [15:0] TQ_MAX_RST = 16'h03E8; // 100.0 % in 0.1 % units
  localparam logic [15:0] SPEED_RST = 16'h0000;
  // torque source selector codes
  localparam logic [3:0] TSEL_NONE = 4'h0;
  localparam logic [3:0] TSEL_AI4 = 4'h4;
  localparam logic [3:0] TSEL_JOY1 = 4'h5;
  localparam logic [3:0] TSEL_JOY2 = 4'h6;
  localparam logic [3:0] TSEL_KEYPAD = 4'h7;
  localparam logic [3:0] TSEL_FIELDBUS = 4'h8;
  localparam logic [3:0] TSEL_MASTER_TQ = 4'h9;
  localparam logic [3:0] TSEL_MASTER_SPC = 4'hA;
  // control word bit positions
  localparam int CW_RAMP_LO_BIT = 4;
  localparam int CW_JOG_ONE_BIT = 7;
  localparam int CW_JOG_TWO_BIT = 8;
  // timing: control cycle enable period
  localparam int CLK_HZ = 40000000;
  localparam int CTRL_CYCLE_US = 1000;
  localparam int CTRL_CYCLE_CLKS = CLK_HZ / 1000000 * CTRL_CYCLE_US;
  // full scale of torque reference (100 %)
  localparam logic signed [15:0] TQ_FULL = 16'sh03E8;
  // speed mode states
  typedef enum logic [1:0] {
    MODE_TORQUE = 2'b00,
    MODE_SPEED = 2'b01
  } ctrl_mode_t;
endpackage

// ==== logic/drive_ref_cond.sv ====
// drive speed and torque reference conditioning with an Avalon-MM register slave
//
// Contract
// - minimum speed applies to adjustable references, skipped while jogging or inching
// - reverse negates inching and preset speed references
// - terminal jog starts drive toward jog reference without separate start
// - terminal jog ignored unless jog enable input is high; an unenabled jog2_in still selects jog reference 2 during fieldbus jog
// - inching disabled while start command is active from active place
// - both inching requests together stop the drive
// - fieldbus jog via control word bits 7/8, ramp bits zero, zero speed
// - after fieldbus jog ramp bits honoured only once speed reaches zero
// - jog references are signed and ignore reverse
// - three preset inputs form binary index, index zero is basic speed
// - torque selector codes 0 none to 10 master speed controller
// - minimum scaling only for analogue 1-4, maximum bounds both signs
// - fieldbus torque unscaled but limited; master sources fully unscaled
// - low-pass filter after load share, before torque step
// - torque inside zero band becomes zero when band positive
// - inside hysteresis band output is plus or minus band by prior sign
// - hysteresis bypassed when negative or below absolute zero band
// - window control: torque mode inside window, speed mode outside
// - window sizes are activation limits; also speed limits if off limits zero
// - returning into window, speed mode ends at off limit
// - ramp takes slew time 0 to 100 %; add before filter, step after
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module drive_ref_cond
  import drive_ref_pkg::*;
#(
  parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
)(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [6:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [15:0] ext_speed_ref_in,
  input wire logic start_in,
  input wire logic reverse_in,
  input wire logic inch1_in,
  input wire logic inch2_in,
  input wire logic jog_enable_in,
  input wire logic jog1_in,
  input wire logic jog2_in,
  input wire logic [2:0] preset_in,
  input wire logic [15:0] control_word_in,
  input wire logic [15:0] actual_speed_in,
  input wire logic [63:0] ai_torque_in,
  input wire logic [15:0] keypad_torque_in,
  input wire logic [15:0] fb_torque_in,
  input wire logic [15:0] master_torque_in,
  input wire logic [15:0] master_spc_in,
  input wire logic [15:0] load_share_in,
  output logic [15:0] speed_ref_out,
  output logic [15:0] torque_ref_out,
  output logic run_out,
  output logic speed_mode_out,
  output logic [2:0] ramp_bits_out,
  output logic [15:0] speed_low_lim_out,
  output logic [15:0] speed_high_lim_out
);

  // register storage
  logic signed [15:0] min_speed_q, inch_ref_q, basic_q, jog_ref1_q, jog_ref2_q;
  logic signed [15:0] preset_q [1:7];
  logic [3:0] tq_sel_q;
  logic signed [15:0] tq_max_q, tq_min_q, tq_zero_q, tq_hyst_q, tq_step_q, tq_add_q;
  logic [15:0] tq_filt_q, tq_slew_q;
  logic signed [15:0] win_neg_q, win_pos_q, win_neg_off_q, win_pos_off_q, ol_floor_q;
  logic [1:0] ctrl_q;
  logic [31:0] rdata_d;

  // control cycle divider
  logic [31:0] div_q;
  logic tick_q;

  // abs and saturating clamp helpers
  function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction
  function automatic logic signed [15:0] clamp16(input logic signed [17:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v > 18'(hi))
    begin
      clamp16 = hi;
    end
    else if (v < 18'(lo))
    begin
      clamp16 = lo;
    end
    else
    begin
      clamp16 = v[15:0];
    end
  endfunction

  // bus: waitrequest idles high and drops for one cycle once a request is seen
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end
  end

  // register writes, byte lanes 0 and 1 hold the 16-bit values
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      min_speed_q <= SPEED_RST; inch_ref_q <= SPEED_RST; basic_q <= SPEED_RST;
      jog_ref1_q <= SPEED_RST; jog_ref2_q <= SPEED_RST;
      for (int i = 1; i <= 7; i++) preset_q[i] <= SPEED_RST;
      tq_sel_q <= TSEL_NONE; tq_max_q <= TQ_MAX_RST; tq_min_q <= 16'h0000;
      tq_filt_q <= 16'h0000; tq_zero_q <= 16'h0000; tq_hyst_q <= 16'h0000;
      win_neg_q <= 16'h0000; win_pos_q <= 16'h0000;
      win_neg_off_q <= 16'h0000; win_pos_off_q <= 16'h0000;
      tq_slew_q <= 16'h0000; tq_step_q <= 16'h0000; tq_add_q <= 16'h0000;
      ol_floor_q <= 16'h0000; ctrl_q <= 2'b00;
    end
    else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[1:0] == 2'b11)
    begin
      case ({avs_address_in, 1'b0})
        OFS_MIN_SPEED: min_speed_q <= avs_writedata_in[15:0];
        OFS_INCH_REF: inch_ref_q <= avs_writedata_in[15:0];
        OFS_BASIC_SPEED: basic_q <= avs_writedata_in[15:0];
        OFS_JOG_REF1: jog_ref1_q <= avs_writedata_in[15:0];
        OFS_JOG_REF2: jog_ref2_q <= avs_writedata_in[15:0];
        OFS_TQ_SEL: tq_sel_q <= avs_writedata_in[3:0];
        OFS_TQ_MAX: tq_max_q <= avs_writedata_in[15:0];
        OFS_TQ_MIN: tq_min_q <= avs_writedata_in[15:0];
        OFS_TQ_FILT: tq_filt_q <= avs_writedata_in[15:0];
        OFS_TQ_ZERO: tq_zero_q <= avs_writedata_in[15:0];
        OFS_TQ_HYST: tq_hyst_q <= avs_writedata_in[15:0];
        OFS_WIN_NEG: win_neg_q <= avs_writedata_in[15:0];
        OFS_WIN_POS: win_pos_q <= avs_writedata_in[15:0];
        OFS_WIN_NEG_OFF: win_neg_off_q <= avs_writedata_in[15:0];
        OFS_WIN_POS_OFF: win_pos_off_q <= avs_writedata_in[15:0];
        OFS_TQ_SLEW: tq_slew_q <= avs_writedata_in[15:0];
        OFS_TQ_STEP: tq_step_q <= avs_writedata_in[15:0];
        OFS_TQ_ADD: tq_add_q <= avs_writedata_in[15:0];
        OFS_OL_FLOOR: ol_floor_q <= avs_writedata_in[15:0];
        OFS_CTRL: ctrl_q <= avs_writedata_in[1:0];
        default:
        begin
          for (int i = 1; i <= 7; i++)
            if ({avs_address_in, 1'b0} == 8'(OFS_PRESET_BASE + 8'(4 * (i - 1))))
              preset_q[i] <= avs_writedata_in[15:0];
        end
      endcase
    end
  end

  // control cycle enable pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == 32'(CYCLE_CLKS - 1));
      div_q <= (div_q == 32'(CYCLE_CLKS - 1)) ? 32'h0000_0000 : div_q + 32'h0000_0001;
    end
  end

  // speed reference selection
  logic fb_jog_q, fb_jog_d, ramp_hold_q;
  logic both_inch, inch_act, term_jog, jog_act, at_zero;
  logic signed [15:0] speed_sel, speed_fin;
  logic stop_req;
  always_comb
  begin
    at_zero = (actual_speed_in == 16'h0000);
    both_inch = inch1_in && inch2_in;
    inch_act = (inch1_in ^ inch2_in) && !start_in;
    term_jog = jog_enable_in && (jog1_in || jog2_in);
    fb_jog_d = fb_jog_q;
    if (control_word_in[CW_JOG_ONE_BIT] || control_word_in[CW_JOG_TWO_BIT])
    begin
      if (control_word_in[CW_RAMP_LO_BIT+2:CW_RAMP_LO_BIT] == 3'b000 && at_zero)
        fb_jog_d = 1'b1;
    end
    else
    begin
      fb_jog_d = 1'b0;
    end
    jog_act = term_jog || fb_jog_q;
    stop_req = both_inch;
    if (jog_act)
    begin
      speed_sel = (jog2_in || control_word_in[CW_JOG_TWO_BIT]) ? jog_ref2_q : jog_ref1_q;
    end
    else if (inch_act)
    begin
      speed_sel = reverse_in ? 16'(-inch_ref_q) : inch_ref_q;
    end
    else if (preset_in != 3'b000)
    begin
      speed_sel = reverse_in ? 16'(-preset_q[preset_in]) : preset_q[preset_in];
    end
    else
    begin
      speed_sel = reverse_in ? 16'(-basic_q) : basic_q;
    end
    speed_fin = speed_sel;
    // presets are fixed settings, so only the basic reference is raised to the minimum
    if (!jog_act && !inch_act && preset_in == 3'b000 && abs16(speed_sel) < min_speed_q)
      speed_fin = speed_sel[15] ? 16'(-min_speed_q) : min_speed_q;
    if (stop_req)
      speed_fin = 16'h0000;
  end

  // fieldbus jog latch and ramp-bit hold
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      fb_jog_q <= 1'b0;
      ramp_hold_q <= 1'b0;
    end
    else
    begin
      fb_jog_q <= fb_jog_d;
      if (fb_jog_q && !fb_jog_d)
        ramp_hold_q <= 1'b1;
      else if (at_zero)
        ramp_hold_q <= 1'b0;
    end
  end

  // fieldbus jog only starts from rest and keeps the ramp bits cleared
  property p_fb_jog_at_rest;
    @(posedge sys_clk_in) disable iff (srst_in) $rose(fb_jog_q) |-> $past(at_zero);
  endproperty
  a_fb_jog_at_rest: assert property (p_fb_jog_at_rest) else $error("fieldbus jog taken while moving");
  property p_ramp_held;
    @(posedge sys_clk_in) disable iff (srst_in) fb_jog_q || ramp_hold_q |=> ramp_bits_out == 3'b000;
  endproperty
  a_ramp_held: assert property (p_ramp_held) else $error("ramp bits passed during jog hold");

  // speed outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      speed_ref_out <= SPEED_RST;
      run_out <= 1'b0;
      ramp_bits_out <= 3'b000;
    end
    else
    begin
      speed_ref_out <= speed_fin;
      run_out <= !stop_req && (start_in || jog_act || inch_act);
      ramp_bits_out <= (fb_jog_q || ramp_hold_q) ? 3'b000 :
                       control_word_in[CW_RAMP_LO_BIT+2:CW_RAMP_LO_BIT];
    end
  end

  // run follows an enabled terminal jog, ignores an unenabled one, stops on both inching inputs
  property p_jog_runs;
    @(posedge sys_clk_in) disable iff (srst_in) jog_enable_in && jog1_in && !both_inch |=> run_out;
  endproperty
  a_jog_runs: assert property (p_jog_runs) else $error("terminal jog did not run");
  property p_jog_needs_en;
    @(posedge sys_clk_in) disable iff (srst_in)
      !jog_enable_in && !start_in && !inch1_in && !inch2_in && !fb_jog_q |=> !run_out;
  endproperty
  a_jog_needs_en: assert property (p_jog_needs_en) else $error("run without enabled jog");
  property p_both_inch_stop;
    @(posedge sys_clk_in) disable iff (srst_in) inch1_in && inch2_in |=> !run_out && speed_ref_out == 16'h0000;
  endproperty
  a_both_inch_stop: assert property (p_both_inch_stop) else $error("double inching did not stop");

  // torque source selection and scaling
  logic signed [15:0] tq_src, tq_scaled, tq_zb, tq_pre;
  logic signed [31:0] tq_shared;
  logic signed [17:0] tq_sum;
  always_comb
  begin
    tq_src = 16'h0000;
    tq_scaled = 16'h0000;
    case (tq_sel_q)
      TSEL_NONE: tq_src = 16'h0000;
      TSEL_JOY1: tq_src = ai_torque_in[15:0];
      TSEL_JOY2: tq_src = ai_torque_in[31:16];
      TSEL_KEYPAD: tq_src = keypad_torque_in;
      TSEL_FIELDBUS: tq_src = fb_torque_in;
      TSEL_MASTER_TQ: tq_src = master_torque_in;
      TSEL_MASTER_SPC: tq_src = master_spc_in;
      default:
        if (tq_sel_q <= TSEL_AI4)
          tq_src = ai_torque_in[16*(tq_sel_q-4'h1) +: 16];
    endcase
    if (tq_sel_q >= 4'h1 && tq_sel_q <= TSEL_AI4)
    begin
      // analogue 0..100 % maps to min..max
      tq_scaled = 16'(32'(tq_min_q) + (32'(tq_max_q - tq_min_q) * 32'(tq_src)) / 32'(TQ_FULL));
    end
    else if (tq_sel_q == TSEL_JOY1 || tq_sel_q == TSEL_JOY2 || tq_sel_q == TSEL_KEYPAD)
    begin
      tq_scaled = 16'((32'(tq_max_q) * 32'(tq_src)) / 32'(TQ_FULL));
    end
    else
    begin
      tq_scaled = tq_src;
    end
    if (tq_sel_q != TSEL_MASTER_TQ && tq_sel_q != TSEL_MASTER_SPC)
      tq_scaled = clamp16(18'(tq_scaled), 16'(-tq_max_q), tq_max_q);
    tq_shared = (32'(tq_scaled) * 32'(signed'(load_share_in))) / 32'(TQ_FULL);
    tq_sum = 18'(signed'(tq_shared[15:0])) + 18'(tq_add_q);
    tq_pre = clamp16(tq_sum, 16'sh8001, 16'sh7FFF);
  end

  // low-pass filter and ramp on the control cycle
  logic signed [31:0] filt_q;
  logic signed [31:0] ramp_q;
  logic signed [15:0] filt_out, ramp_out, hyst_prev_q, tq_hy;
  logic signed [31:0] ramp_step;
  always_comb
  begin
    filt_out = filt_q[31:16];
    ramp_out = ramp_q[31:16];
    // per-cycle increment: full scale over slew time in cycles
    ramp_step = (tq_slew_q == 16'h0000) ? 32'sh7FFF_FFFF :
                32'((32'(TQ_FULL) <<< 16) / 32'(tq_slew_q));
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      filt_q <= 32'h0000_0000;
      ramp_q <= 32'h0000_0000;
    end
    else if (tick_q)
    begin
      // first order, time constant in control cycles
      filt_q <= filt_q + ((32'(tq_pre) <<< 16) - filt_q) / signed'(32'(tq_filt_q) + 32'h0000_0001);
      if ((32'(filt_out) <<< 16) - ramp_q > ramp_step)
        ramp_q <= ramp_q + ramp_step;
      else if (ramp_q - (32'(filt_out) <<< 16) > ramp_step)
        ramp_q <= ramp_q - ramp_step;
      else
        ramp_q <= 32'(filt_out) <<< 16;
    end
  end

  // zero band, hysteresis, then torque step
  always_comb
  begin
    tq_zb = ramp_out;
    if (tq_zero_q > 16'sh0000 && abs16(ramp_out) <= tq_zero_q)
      tq_zb = 16'h0000;
    tq_hy = tq_zb;
    if (!tq_hyst_q[15] && tq_hyst_q >= abs16(tq_zero_q) && abs16(tq_zb) < tq_hyst_q)
      tq_hy = hyst_prev_q[15] ? 16'(-tq_hyst_q) : tq_hyst_q;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      hyst_prev_q <= 16'h0000;
      torque_ref_out <= 16'h0000;
    end
    else
    begin
      hyst_prev_q <= tq_hy;
      torque_ref_out <= clamp16(18'(tq_hy) + 18'(tq_step_q), 16'sh8001, 16'sh7FFF);
    end
  end

  // window control and open-loop floor
  ctrl_mode_t mode_q, mode_d;
  logic signed [16:0] err;
  logic off_zero;
  always_comb
  begin
    err = 17'(signed'(actual_speed_in)) - 17'(speed_fin);
    off_zero = (win_neg_off_q == 16'sh0000) && (win_pos_off_q == 16'sh0000);
    mode_d = mode_q;
    case (mode_q)
      MODE_TORQUE:
        if (ctrl_q[CTRL_WINDOW_EN_BIT] && (err > 17'(win_pos_q) || err < 17'(-win_neg_q)))
          mode_d = MODE_SPEED;
      MODE_SPEED:
        if (!ctrl_q[CTRL_WINDOW_EN_BIT] || (err <= 17'(win_pos_off_q) && err >= 17'(-win_neg_off_q)))
          mode_d = MODE_TORQUE;
      default: mode_d = MODE_TORQUE;
    endcase
    if (ctrl_q[CTRL_OPEN_LOOP_BIT] && abs16(actual_speed_in) < ol_floor_q)
      mode_d = MODE_SPEED;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      mode_q <= MODE_TORQUE;
      speed_mode_out <= 1'b0;
      speed_low_lim_out <= 16'h0000;
      speed_high_lim_out <= 16'h0000;
    end
    else
    begin
      mode_q <= mode_d;
      speed_mode_out <= (mode_d == MODE_SPEED);
      speed_low_lim_out <= off_zero ? 16'(speed_fin - win_neg_q) : 16'sh8001;
      speed_high_lim_out <= off_zero ? 16'(speed_fin + win_pos_q) : 16'sh7FFF;
    end
  end

  // with window and open-loop control both off the drive stays in torque mode
  property p_window_off;
    @(posedge sys_clk_in) disable iff (srst_in) ctrl_q == 2'b00 |=> !speed_mode_out;
  endproperty
  a_window_off: assert property (p_window_off) else $error("speed mode with window off");

  // read mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case ({avs_address_in, 1'b0})
      OFS_TQ_SEL: rdata_d = {28'h0, tq_sel_q};
      OFS_TQ_MAX: rdata_d = {16'h0, tq_max_q};
      OFS_TQ_SLEW: rdata_d = {16'h0, tq_slew_q};
      OFS_CTRL: rdata_d = {30'h0, ctrl_q};
      OFS_STATUS: rdata_d = {28'h0, fb_jog_q, stop_req, jog_act, mode_q == MODE_SPEED};
      OFS_SPEED_OUT: rdata_d = {16'h0, speed_ref_out};
      OFS_TORQUE_OUT: rdata_d = {16'h0, torque_ref_out};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      avs_readdata_out <= 32'h0000_0000;
    else
      avs_readdata_out <= rdata_d;
  end

endmodule

// ==== test/drive_ref_partner.sv ====
// far-side model: digital input terminals and fieldbus master
`timescale 1ns/1ps
module drive_ref_partner (
  input wire logic clk_in,
  input wire logic [1:0] jog_req_in,
  input wire logic skip_enable_in,
  input wire logic [1:0] fb_jog_in,
  input wire logic [2:0] ramp_in,
  output logic jog_enable_out,
  output logic [1:0] jog_out,
  output logic [15:0] control_word_out
);
  // enable rises a cycle ahead of the jog request unless told to skip it
  always_ff @(posedge clk_in)
  begin
    jog_enable_out <= (|jog_req_in) & ~skip_enable_in;
    jog_out <= jog_req_in & {2{jog_enable_out | skip_enable_in}};
  end
  // ramp bits are forced to zero whenever a fieldbus jog is asked for
  always_ff @(posedge clk_in)
  begin
    control_word_out <= {7'h00, fb_jog_in, ((|fb_jog_in) ? 3'h0 : ramp_in), 4'h0};
  end
endmodule

// ==== test/test_drive_ref_cond.sv ====
// self-checking bench for the drive reference conditioning block
`timescale 1ns/1ps
module test_drive_ref_cond;
  import drive_ref_pkg::*;
  localparam int CYC = 4;
  localparam int SPD = 0;
  localparam int TQ = 1;
  localparam int RUN = 2;
  localparam int MODE = 3;
  localparam int RAMP = 4;
  localparam int LLIM = 5;
  localparam int HLIM = 6;
  logic sys_clk_in;
  logic srst_in = 1'b1;
  logic [6:0] addr = 7'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic start = 1'b0;
  logic rev = 1'b0;
  logic inch1 = 1'b0;
  logic inch2 = 1'b0;
  logic [2:0] preset = 3'h0;
  logic [15:0] actual = 16'h0000;
  logic [15:0] fbt = 16'h0000;
  logic [15:0] mt = 16'h0000;
  logic [15:0] load = 16'h03E8;
  logic [1:0] jog_req = 2'h0;
  logic skip_en = 1'b0;
  logic [1:0] fb_jog = 2'h0;
  logic [2:0] ramp = 3'h0;
  logic jog_en;
  logic [1:0] jog;
  logic [15:0] cw;
  logic [31:0] rdata;
  logic wreq;
  logic [15:0] spd;
  logic [15:0] tq;
  logic run;
  logic mode;
  logic [2:0] rbits;
  logic [15:0] llim;
  logic [15:0] hlim;
  logic [31:0] rd;
  logic [15:0] exp_v;
  int bad_count = 0;
  int checks_done = 0;
  int n;

  drive_ref_cond #(.CYCLE_CLKS(CYC)) dut_u (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .ext_speed_ref_in(16'h0000),
    .start_in(start), .reverse_in(rev), .inch1_in(inch1), .inch2_in(inch2), .jog_enable_in(jog_en),
    .jog1_in(jog[0]), .jog2_in(jog[1]), .preset_in(preset), .control_word_in(cw),
    .actual_speed_in(actual), .ai_torque_in(64'h0), .keypad_torque_in(16'h0000),
    .fb_torque_in(fbt), .master_torque_in(mt), .master_spc_in(16'h0000), .load_share_in(load),
    .speed_ref_out(spd), .torque_ref_out(tq), .run_out(run), .speed_mode_out(mode),
    .ramp_bits_out(rbits), .speed_low_lim_out(llim), .speed_high_lim_out(hlim)
  );

  drive_ref_partner far_u (
    .clk_in(sys_clk_in), .jog_req_in(jog_req), .skip_enable_in(skip_en), .fb_jog_in(fb_jog),
    .ramp_in(ramp), .jog_enable_out(jog_en), .jog_out(jog), .control_word_out(cw)
  );

  // 40 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // verdict and end of run
  task automatic finish_test();
  begin
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // compare one 16-bit result
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
  begin
    checks_done++;
    if (got !== want)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  end
  endtask

  // one Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [15:0] wd);
    int k;
  begin
    k = 0;
    @(posedge sys_clk_in);
    addr <= ofs[7:1];
    rd_en <= ~wr;
    wr_en <= wr;
    wdata <= {16'h0000, wd};
    do
    begin
      @(posedge sys_clk_in);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    if (k >= 20)
    begin
      bad_count++;
      finish_test();
    end
    rd = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [15:0] wd);
    bus(1'b1, ofs, wd);
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [15:0] want);
  begin
    bus(1'b0, ofs, 16'h0000);
    chk(rd[15:0], want);
  end
  endtask

  function automatic logic [15:0] pick(input int sel);
    case (sel)
      SPD: return spd;
      TQ: return tq;
      RUN: return {15'h0000, run};
      MODE: return {15'h0000, mode};
      LLIM: return llim;
      HLIM: return hlim;
      default: return {13'h0000, rbits};
    endcase
  endfunction

  // wait a bounded time for an output to reach its expected value
  task automatic wait_eq(input int sel, input logic [15:0] want);
    int k;
  begin
    k = 0;
    while (pick(sel) !== want && k < 400)
    begin
      @(posedge sys_clk_in);
      k++;
    end
    chk(pick(sel), want);
    if (k >= 400)
      finish_test();
  end
  endtask

  // an output must keep its value for ten control cycles
  task automatic hold_eq(input int sel, input logic [15:0] want);
    repeat (10 * CYC)
    begin
      @(posedge sys_clk_in);
      if (pick(sel) !== want)
        chk(pick(sel), want);
    end
    chk(pick(sel), want);
  endtask

  // hang guard
  initial
  begin
    #(25 * 80000);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rdchk(OFS_TQ_MAX, TQ_MAX_RST);
    rdchk(8'h78, 16'h0000);
    for (int i = 0; i <= 10; i++)
    begin
      wr(OFS_TQ_SEL, 16'(i));
      rdchk(OFS_TQ_SEL, 16'(i));
    end
    // every preset index forward, indices 1 to 7 also reversed
    wr(OFS_BASIC_SPEED, 16'h0050);
    for (int i = 1; i < 8; i++)
      wr(OFS_PRESET_BASE + 8'(4 * (i - 1)), 16'(i * 256));
    start <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      preset <= 3'(i);
      rev <= i[3];
      exp_v = (i[2:0] == 3'h0) ? 16'h0050 : {5'h00, 3'(i), 8'h00};
      if (i[3] == 1'b1)
        exp_v = -exp_v;
      if (i != 8)
        wait_eq(SPD, exp_v);
    end
    // window control around the final setpoint
    preset <= 3'h1;
    rev <= 1'b0;
    actual <= 16'h0100;
    wr(OFS_WIN_NEG, 16'h0040);
    wr(OFS_WIN_POS, 16'h0040);
    wr(OFS_WIN_NEG_OFF, 16'h0020);
    wr(OFS_WIN_POS_OFF, 16'h0020);
    wr(OFS_CTRL, 16'h0001);
    wait_eq(MODE, 16'h0000);
    actual <= 16'h0180;
    wait_eq(MODE, 16'h0001);
    actual <= 16'h0130;
    hold_eq(MODE, 16'h0001);
    actual <= 16'h0110;
    wait_eq(MODE, 16'h0000);
    wait_eq(HLIM, 16'h7FFF);
    wr(OFS_WIN_NEG_OFF, 16'h0000);
    wr(OFS_WIN_POS_OFF, 16'h0000);
    wait_eq(HLIM, 16'h0140);
    wait_eq(LLIM, 16'h00C0);
    // open-loop floor
    wr(OFS_CTRL, 16'h0002);
    wr(OFS_OL_FLOOR, 16'h0200);
    actual <= 16'h0100;
    wait_eq(MODE, 16'h0001);
    actual <= 16'h0300;
    wait_eq(MODE, 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    actual <= 16'h0000;
    // inching below the floor, with reverse, blocked by start, both at once
    wr(OFS_MIN_SPEED, 16'h0200);
    wr(OFS_INCH_REF, 16'h0080);
    start <= 1'b0;
    inch1 <= 1'b1;
    wait_eq(SPD, 16'h0080);
    wait_eq(RUN, 16'h0001);
    rev <= 1'b1;
    wait_eq(SPD, 16'hFF80);
    start <= 1'b1;
    wait_eq(SPD, 16'hFF00);
    start <= 1'b0;
    inch2 <= 1'b1;
    wait_eq(RUN, 16'h0000);
    inch1 <= 1'b0;
    inch2 <= 1'b0;
    preset <= 3'h0;
    wait_eq(SPD, 16'hFE00);
    // terminal jog needs its enable and ignores reverse
    wr(OFS_JOG_REF1, 16'hFF38);
    wr(OFS_JOG_REF2, 16'h0070);
    skip_en <= 1'b1;
    jog_req <= 2'b01;
    hold_eq(RUN, 16'h0000);
    jog_req <= 2'b00;
    skip_en <= 1'b0;
    @(posedge sys_clk_in);
    jog_req <= 2'b01;
    wait_eq(RUN, 16'h0001);
    wait_eq(SPD, 16'hFF38);
    jog_req <= 2'b10;
    wait_eq(SPD, 16'h0070);
    jog_req <= 2'b00;
    rev <= 1'b0;
    wait_eq(RUN, 16'h0000);
    // fieldbus jog only from standstill; ramp bits back only at zero speed
    ramp <= 3'h5;
    wait_eq(RAMP, 16'h0005);
    actual <= 16'h0100;
    fb_jog <= 2'b01;
    hold_eq(RUN, 16'h0000);
    fb_jog <= 2'b00;
    actual <= 16'h0000;
    @(posedge sys_clk_in);
    fb_jog <= 2'b10;
    wait_eq(SPD, 16'h0070);
    bus(1'b0, OFS_STATUS, 16'h0000);
    chk({15'h0000, rd[ST_FB_JOG_BIT]}, 16'h0001);
    actual <= 16'h0100;
    fb_jog <= 2'b00;
    hold_eq(RAMP, 16'h0000);
    actual <= 16'h0000;
    wait_eq(RAMP, 16'h0005);
    // torque chain: limits, zero band, hysteresis
    wr(OFS_TQ_SEL, {12'h000, TSEL_FIELDBUS});
    wr(OFS_TQ_ZERO, 16'h0010);
    wr(OFS_TQ_HYST, 16'hFFC0);
    fbt <= 16'h0500;
    wait_eq(TQ, TQ_MAX_RST);
    fbt <= 16'hFB00;
    wait_eq(TQ, 16'hFC18);
    fbt <= 16'h000C;
    wait_eq(TQ, 16'h0000);
    fbt <= 16'h0020;
    wait_eq(TQ, 16'h0020);
    wr(OFS_TQ_HYST, 16'h0040);
    fbt <= 16'h0100;
    wait_eq(TQ, 16'h0100);
    fbt <= 16'h0020;
    wait_eq(TQ, 16'h0040);
    fbt <= 16'hFF00;
    wait_eq(TQ, 16'hFF00);
    fbt <= 16'h0020;
    wait_eq(TQ, 16'hFFC0);
    // master torque unscaled, step added after the ramp
    wr(OFS_TQ_SEL, {12'h000, TSEL_MASTER_TQ});
    mt <= 16'h0500;
    wait_eq(TQ, 16'h0500);
    wr(OFS_TQ_STEP, 16'h0010);
    wait_eq(TQ, 16'h0510);
    wr(OFS_TQ_STEP, 16'h0000);
    mt <= 16'h0000;
    wait_eq(TQ, 16'h0040);
    // filter constant of three control cycles closes a quarter of the gap per cycle
    wr(OFS_TQ_FILT, 16'h0003);
    mt <= 16'h0400;
    wait_eq(TQ, 16'h0100);
    wait_eq(TQ, 16'h01C0);
    wr(OFS_TQ_FILT, 16'h0000);
    mt <= 16'h0000;
    wait_eq(TQ, 16'h0040);
    // slew time of four control cycles for 0 to 100 percent
    wr(OFS_TQ_SLEW, 16'h0004);
    mt <= 16'h03E8;
    n = 0;
    while (tq !== 16'h03E8 && n < 400)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(16'(n >= 3 * CYC && n <= 7 * CYC), 16'h0001);
    finish_test();
  end
endmodule
